// file: include/packet_status_pkg.sv
// Constants, types and layouts shared by the packet status readout and group check logic
package packet_status_pkg;

  localparam logic [3:0]  ADDR_DATA      = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h1;
  localparam logic [3:0]  ADDR_INDEX     = 4'h2;
  localparam logic [3:0]  ADDR_CHECK_IN  = 4'h6;

  localparam int          BIT_DEPTH      = 7;
  localparam int          BIT_BLOCK_LOCK = 6;
  localparam int          BIT_FRAME_LOCK = 5;
  localparam int          BIT_UNCORR     = 4;
  localparam int          BIT_PARITY     = 3;
  localparam int          BIT_HEAD       = 2;
  localparam int          BIT_GROUP_OK   = 1;
  localparam int          BIT_REALTIME   = 0;

  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam logic [7:0]  INDEX_RESET    = 8'h00;
  localparam logic [7:0]  MAX_DATA_INDEX = 8'hBD;
  localparam logic [7:0]  MAX_PAR_INDEX  = 8'h51;

  localparam int          DATA_BITS      = 176;
  localparam logic [4:0]  DATA_BYTES     = 5'h16;
  localparam logic [7:0]  SER_HEAD_BITS  = 8'h10;
  localparam logic [7:0]  SER_DATA_END   = 8'hC0;

  localparam logic [7:0]  SER_ADDR_DATA  = 8'hFB;
  localparam logic [7:0]  SER_ADDR_CHECK = 8'hFC;
  localparam logic [7:0]  SER_ADDR_REGS  = 8'hFD;

  localparam int          CRC_WIDTH      = 16;
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_INIT       = 16'h0000;

  // Update window ahead of the interrupt edge and the clock it is counted in
  localparam int          UPDATE_WIN_NS  = 1000000;
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          UPDATE_WIN_CYC = UPDATE_WIN_NS / CLK_PERIOD_NS;
  localparam logic [1:0]  INT_LEAD_CYC   = 2'h2;

  // Pin order: {SER_DI, SER_CL, SER_CE, DMA_ACK, WR_N, RD_N, CS_N}
  localparam int          PIN_COUNT      = 7;
  localparam logic [6:0]  PIN_IDLE       = 7'h07;

  typedef enum logic [1:0] {
    METHOD_A       = 2'h0,
    METHOD_A_PRIME = 2'h1,
    METHOD_B       = 2'h2,
    METHOD_C       = 2'h3
  } frame_method_e;

  typedef enum logic [3:0] {
    SER_ADDR  = 4'b0001,
    SER_READ  = 4'b0010,
    SER_CHECK = 4'b0100,
    SER_IDLE  = 4'b1000
  } ser_state_e;

  typedef struct packed {
    logic                 vh_applied;
    logic                 block_locked;
    logic                 frame_locked;
    logic                 uncorrectable;
    logic                 is_parity;
    logic                 is_head;
    logic                 is_realtime;
    logic [7:0]           block_index;
    logic [DATA_BITS-1:0] data;
  } packet_info_s;

endpackage : packet_status_pkg

// file: logic/group_check_crc.sv
// Byte-wide divider for the data-group check word
`timescale 1ns/10ps
`default_nettype none
module group_check_crc
  import packet_status_pkg::*;
(
  input  wire logic       clk,        // System clock
  input  wire logic       rst_n,      // Async reset, active low
  input  wire logic       clear,      // Level; holds remainder at zero
  input  wire logic       byte_valid, // One-cycle byte strobe
  input  wire logic [7:0] byte_in,    // Group byte, first bit in bit 7
  output logic            zero        // Remainder is all zero
);

  logic [CRC_WIDTH-1:0] rem_reg;
  logic [CRC_WIDTH-1:0] rem_next;

  function automatic logic [CRC_WIDTH-1:0] crc_byte(input logic [CRC_WIDTH-1:0] c, input logic [7:0] b);
    logic [CRC_WIDTH-1:0] r;
    logic                 fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[CRC_WIDTH-1] ^ b[i];
      r = {r[CRC_WIDTH-2:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
    end
    return r;
  endfunction : crc_byte

  // No length counter: the remainder simply keeps dividing
  assign rem_next = clear ? CRC_INIT : (byte_valid ? crc_byte(rem_reg, byte_in) : rem_reg);
  assign zero     = (rem_reg == CRC_INIT);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rem_reg <= CRC_INIT;
    else        rem_reg <= rem_next;
  end

  a_clear_zeroes: assert property (@(posedge clk) disable iff (!rst_n) clear |=> zero)
    else $error("remainder not zero after clear");

endmodule : group_check_crc
`default_nettype wire

// file: logic/packet_status_readout.sv
// Status and index registers, post-correction readout and group check front end
`timescale 1ns/10ps
`default_nettype none
module packet_status_readout
  import packet_status_pkg::*;
#(
  parameter int UPDATE_WIN = UPDATE_WIN_CYC // Cycles of the update window
)(
  input  wire logic          CLK_SYS,          // 25 MHz system clock
  input  wire logic          RST_N,            // Async reset, active low
  input  wire logic          PKT_VALID,        // One-cycle pulse, packet ready
  input  wire packet_info_s  PKT_INFO,         // Packet flags, index and data
  input  wire frame_method_e FRAME_METHOD,     // Frame structure in use
  input  wire logic          VERTICAL_CORRECTION_HALT,         // Vertical correction halted
  input  wire logic          GROUP_CHECK_CLEAR,// Clear the check remainder
  input  wire logic          BUS_16,           // Parallel bus is 16 bits wide
  input  wire logic          DMA_EN,           // Data reads use DMA
  input  wire logic          DMA_READ_ON_ACK,  // Acknowledge strobes the read
  input  wire logic          DMA_REQUEST_ACTIVE_HIGH, // Request polarity
  input  wire logic          DMA_ACKNOWLEDGE_ACTIVE_HIGH, // Acknowledge polarity
  input  wire logic          CS_N,             // Chip select pin
  input  wire logic          RD_N,             // Read strobe pin
  input  wire logic          WR_N,             // Write strobe pin
  input  wire logic [3:0]    ADDR,             // Register address lines
  input  wire logic [15:0]   D_IN,             // Data bus input
  output logic      [15:0]   D_OUT,            // Data bus output
  output logic               D_OE,             // Data bus drive enable
  input  wire logic          DMA_ACK,          // DMA acknowledge pin
  output logic               DMA_REQ,          // DMA request pin
  output logic               INT_N,            // Packet interrupt, active low
  output logic               GROUP_CHECK_OK,   // Check remainder all zero
  input  wire logic          SER_CE,           // Serial enable pin
  input  wire logic          SER_CL,           // Serial clock pin
  input  wire logic          SER_DI,           // Serial data in pin
  output logic               SER_DO_OUT,       // Serial data out level
  output logic               SER_DO_OE         // Serial data out drive enable
);

  // Three-stage pin synchronisers; a level counts once stages two and three agree
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] s1_reg;
  logic [PIN_COUNT-1:0] s2_reg;
  logic [PIN_COUNT-1:0] s3_reg;
  logic [PIN_COUNT-1:0] pin_reg;
  logic [PIN_COUNT-1:0] pin_next;

  assign pin_raw  = {SER_DI, SER_CL, SER_CE, DMA_ACK, WR_N, RD_N, CS_N};
  assign pin_next = (s2_reg & s3_reg) | (pin_reg & (s2_reg ^ s3_reg));

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s1_reg  <= PIN_IDLE;
      s2_reg  <= PIN_IDLE;
      s3_reg  <= PIN_IDLE;
      pin_reg <= PIN_IDLE;
    end else begin
      s1_reg  <= pin_raw;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      pin_reg <= pin_next;
    end
  end

  wire cs_s   = ~pin_reg[0];
  wire rd_s   = ~pin_reg[1];
  wire wr_s   = ~pin_reg[2];
  wire ack_s  = (pin_reg[3] == DMA_ACKNOWLEDGE_ACTIVE_HIGH);
  wire ce_s   = pin_reg[4];
  wire cl_s   = pin_reg[5];
  wire di_s   = pin_reg[6];

  // Packet capture
  logic [7:0]           status_reg;
  logic [7:0]           index_reg;
  logic [DATA_BITS-1:0] data_reg;
  logic [4:0]           ptr_reg;
  logic [4:0]           ptr_next;
  logic                 avail_reg;
  logic [1:0]           lead_reg;
  logic                 int_n_reg;
  logic                 crc_zero;

  wire rt_ok    = PKT_INFO.is_realtime & (FRAME_METHOD == METHOD_A_PRIME);
  // Parity blocks coming out of the vertical pass are dropped outright
  wire load     = PKT_VALID & ~(PKT_INFO.vh_applied & PKT_INFO.is_parity);

  logic [7:0] status_new;
  always_comb begin
    status_new                 = STATUS_RESET;
    status_new[BIT_DEPTH]      = PKT_INFO.vh_applied & ~rt_ok;
    status_new[BIT_BLOCK_LOCK] = PKT_INFO.block_locked;
    status_new[BIT_FRAME_LOCK] = PKT_INFO.frame_locked;
    status_new[BIT_UNCORR]     = PKT_INFO.uncorrectable;
    status_new[BIT_PARITY]     = PKT_INFO.is_parity & ~rt_ok;
    status_new[BIT_HEAD]       = PKT_INFO.is_head;
    status_new[BIT_REALTIME]   = rt_ok;
  end

  // Byte of the packet data, first bit at bit 7; past the end reads zero
  function automatic logic [7:0] byte_at(input logic [DATA_BITS-1:0] d, input logic [4:0] i);
    if (i >= DATA_BYTES) return 8'h00;
    return d[(DATA_BITS - 8) - 8 * int'(i) +: 8];
  endfunction : byte_at

  // Group check bit is live, so the value read is the one just before the read
  wire [7:0] status_view = {status_reg[7:2], crc_zero, status_reg[0]};

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      status_reg <= STATUS_RESET;
      index_reg  <= INDEX_RESET;
      data_reg   <= '0;
    end else if (load) begin
      status_reg <= status_new;
      // Index is passed through as given; under a halted vertical pass it means nothing
      index_reg  <= PKT_INFO.block_index;
      data_reg   <= PKT_INFO.data;
    end
  end

  // Interrupt edge follows the register update by a fixed lead, well inside the window
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lead_reg  <= 2'h0;
      int_n_reg <= 1'b1;
    end else if (load) begin
      lead_reg  <= INT_LEAD_CYC;
      int_n_reg <= 1'b1;
    end else if (lead_reg != 2'h0) begin
      lead_reg  <= lead_reg - 2'h1;
      int_n_reg <= (lead_reg != 2'h1);
    end
  end
  assign INT_N = int_n_reg;

  // Parallel port strobes
  logic rd_act_reg;
  logic wr_act_reg;
  logic [15:0] dout_reg;
  logic        oe_reg;

  wire dma_rd    = DMA_EN & DMA_READ_ON_ACK & ack_s;
  wire rd_act    = (cs_s & rd_s) | dma_rd;
  wire rd_start  = rd_act & ~rd_act_reg;
  wire rd_end    = ~rd_act & rd_act_reg;
  wire wr_start  = cs_s & wr_s & ~wr_act_reg;
  // Data reads assume address zero, so a DMA cycle needs no address decode
  wire data_sel  = dma_rd | (ADDR == ADDR_DATA);
  wire step2     = BUS_16;
  wire [15:0] data_word = step2 ? {byte_at(data_reg, ptr_reg), byte_at(data_reg, ptr_reg + 5'h1)}
                                : {8'h00, byte_at(data_reg, ptr_reg)};

  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (data_sel)                  rd_word = data_word;
    else if (ADDR == ADDR_STATUS)  rd_word = {8'h00, status_view};
    else if (ADDR == ADDR_INDEX)   rd_word = {8'h00, index_reg};
  end

  // Data reads step the pointer and a load clears it; status and index reads leave the pointer and status register alone
  always_comb begin
    ptr_next = ptr_reg;
    if (load)
      ptr_next = 5'h00;
    else if (rd_end && data_sel && ptr_reg < DATA_BYTES)
      ptr_next = ptr_reg + (step2 ? 5'h2 : 5'h1);
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      dout_reg   <= 16'h0000;
      oe_reg     <= 1'b0;
      ptr_reg    <= 5'h00;
      avail_reg  <= 1'b0;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= cs_s & wr_s;
      if (rd_start) dout_reg <= rd_word;
      oe_reg     <= rd_act;
      ptr_reg    <= ptr_next;
      avail_reg  <= load | (avail_reg & (ptr_next < DATA_BYTES));
    end
  end

  assign D_OUT = dout_reg;
  assign D_OE  = oe_reg;

  // Request drops while a transfer is in flight so one word moves per request
  wire dma_request_level = DMA_EN & avail_reg & ~rd_act_reg;
  assign DMA_REQ  = DMA_REQUEST_ACTIVE_HIGH ? dma_request_level : ~dma_request_level;

  // Serial port: address shifted in while enable is low, mode chosen on enable rise
  ser_state_e ser_state_reg;
  ser_state_e ser_state_next;
  logic       ce_reg;
  logic       cl_reg;
  logic [7:0] addr_sh_reg;
  logic [7:0] bit_idx_reg;
  logic [7:0] bit_lim_reg;
  logic [7:0] in_sh_reg;
  logic [2:0] in_cnt_reg;
  logic       do_bit_reg;
  logic       do_oe_reg;

  wire cl_rise = cl_s & ~cl_reg;
  wire ce_rise = ce_s & ~ce_reg;

  function automatic logic ser_bit(input logic [7:0] i, input logic [7:0] st,
                                   input logic [7:0] ix, input logic [DATA_BITS-1:0] d);
    if (i < 8'h08)         return st[i[2:0]];
    if (i < SER_HEAD_BITS) return ix[i[2:0]];
    return d[DATA_BITS - 1 - int'(i - SER_HEAD_BITS)];
  endfunction : ser_bit

  always_comb begin
    ser_state_next = ser_state_reg;
    case (ser_state_reg)
      SER_ADDR: begin
        if (ce_rise) begin
          if (addr_sh_reg == SER_ADDR_DATA || addr_sh_reg == SER_ADDR_REGS) ser_state_next = SER_READ;
          else if (addr_sh_reg == SER_ADDR_CHECK) ser_state_next = SER_CHECK;
          else ser_state_next = SER_IDLE;
        end
      end
      SER_READ, SER_CHECK, SER_IDLE: begin
        if (!ce_s) ser_state_next = SER_ADDR;
      end
      default: ser_state_next = SER_ADDR;
    endcase
  end

  wire ser_byte = (ser_state_reg == SER_CHECK) && cl_rise && (in_cnt_reg == 3'h7);
  wire [7:0] ser_byte_val = {di_s, in_sh_reg[7:1]};
  wire [7:0] lim_sel = (addr_sh_reg == SER_ADDR_REGS) ? SER_HEAD_BITS : SER_DATA_END;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ser_state_reg <= SER_ADDR;
      ce_reg        <= 1'b0;
      cl_reg        <= 1'b0;
      addr_sh_reg   <= 8'h00;
      bit_idx_reg   <= 8'h00;
      bit_lim_reg   <= 8'h00;
      in_sh_reg     <= 8'h00;
      in_cnt_reg    <= 3'h0;
    end else begin
      ser_state_reg <= ser_state_next;
      ce_reg        <= ce_s;
      cl_reg        <= cl_s;
      if (ser_state_reg == SER_ADDR && !ce_s && cl_rise) addr_sh_reg <= {di_s, addr_sh_reg[7:1]};
      if (ce_rise) begin
        bit_idx_reg <= 8'h00;
        bit_lim_reg <= lim_sel;
        in_cnt_reg  <= 3'h0;
      end else if (cl_rise && ser_state_reg == SER_READ && bit_idx_reg < bit_lim_reg) begin
        bit_idx_reg <= bit_idx_reg + 8'h01;
      end else if (cl_rise && ser_state_reg == SER_CHECK) begin
        in_sh_reg   <= ser_byte_val;
        in_cnt_reg  <= in_cnt_reg + 3'h1;
      end
    end
  end

  // Open drain: drive only to pull the line low
  wire ser_drive = (ser_state_reg == SER_READ) && ce_s && (bit_idx_reg < bit_lim_reg);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      do_bit_reg <= 1'b1;
      do_oe_reg  <= 1'b0;
    end else begin
      do_bit_reg <= ser_bit(bit_idx_reg, status_view, index_reg, data_reg);
      do_oe_reg  <= ser_drive & ~ser_bit(bit_idx_reg, status_view, index_reg, data_reg);
    end
  end
  assign SER_DO_OUT = 1'b0;
  assign SER_DO_OE  = do_oe_reg;

  // Group check: parallel writes to the check register and serial check bytes
  wire       par_byte  = wr_start && (ADDR == ADDR_CHECK_IN);
  wire       chk_valid = par_byte | ser_byte;
  wire [7:0] chk_byte  = par_byte ? D_IN[7:0] : ser_byte_val;

  group_check_crc u_check (
    .clk        (CLK_SYS),
    .rst_n      (RST_N),
    .clear      (GROUP_CHECK_CLEAR),
    .byte_valid (chk_valid),
    .byte_in    (chk_byte),
    .zero       (crc_zero)
  );
  assign GROUP_CHECK_OK = crc_zero;

  a_depth_realtime: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    status_reg[BIT_REALTIME] |-> !status_reg[BIT_DEPTH] && !status_reg[BIT_PARITY])
    else $error("depth or parity flag set on real-time packet");

  a_realtime_method: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    load && FRAME_METHOD != METHOD_A_PRIME |=> !status_reg[BIT_REALTIME])
    else $error("real-time flag outside method A-prime");

  a_int_after_update: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $fell(INT_N) |-> $past(load, 3) && !$past(load, 2) && !$past(load))
    else $error("interrupt edge not two cycles after update");

  a_int_follows_load: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    load ##1 !load [*2] |=> !INT_N)
    else $error("interrupt missing after update");

  a_no_parity_out: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    PKT_VALID && PKT_INFO.vh_applied && PKT_INFO.is_parity |=> $stable(status_reg) && $stable(index_reg))
    else $error("post-vertical parity block reached registers");

  a_status_read_quiet: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    rd_end && !data_sel && !load |=> $stable(ptr_reg) && $stable(status_reg))
    else $error("register read changed state");

  a_ptr_bound: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ptr_reg <= DATA_BYTES)
    else $error("data pointer beyond 22 bytes");

  a_dma_request_level: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !DMA_EN |-> DMA_REQ == !DMA_REQUEST_ACTIVE_HIGH)
    else $error("request active with DMA off");

  a_group_bit_live: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    rd_start && ADDR == ADDR_STATUS && !dma_rd |=> dout_reg[BIT_GROUP_OK] == $past(crc_zero))
    else $error("status bit 1 differs from remainder state");

  a_serial_head: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    ser_drive && bit_idx_reg < 8'h08 |=> do_bit_reg == $past(status_view[bit_idx_reg[2:0]]))
    else $error("serial status bit out of order");

endmodule : packet_status_readout
`default_nettype wire

// file: tb/host_port_model.sv
// Host CPU model on the parallel and serial ports: register, DMA and serial reads, check writes, check clear
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  input  wire logic        clk,   // System clock
  input  wire logic [15:0] d_out, // Read word from device
  input  wire logic        d_oe,  // Device drives the bus
  input  wire logic        ser_do_oe, // Device sinks the serial data line
  output logic             cs_n,  // Chip select
  output logic             rd_n,  // Read strobe
  output logic             wr_n,  // Write strobe
  output logic [3:0]       addr,  // Register address lines
  output logic [15:0]      d_in,  // Write data
  output logic             clr,   // Group check clear level
  output logic             dma_acknowledge,  // DMA acknowledge pin
  output logic             ack_rd, // Acknowledge strobes data reads
  output logic             ser_ce, // Serial enable
  output logic             ser_cl, // Serial clock
  output logic             ser_di  // Serial data to device
);
  logic hang;
  initial begin
    {cs_n, rd_n, wr_n, clr, hang} = 5'h1C;
    addr = 4'h0;
    d_in = 16'hA5C3;
    {dma_acknowledge, ack_rd, ser_ce, ser_cl, ser_di} = 5'h00;
  end
  // Acknowledge settles at its idle level before the ack path is armed
  task automatic dma_read(input logic pol, output logic [15:0] q);
    int n;
    @(negedge clk);
    addr = 4'h0;
    dma_acknowledge = ~pol;
    repeat (6) @(negedge clk);
    ack_rd = 1'b1;
    dma_acknowledge = pol;
    for (n = 0; n < 20 && d_oe !== 1'b1; n++) @(negedge clk);
    hang |= (n == 20);
    q = d_out;
    dma_acknowledge = ~pol;
    for (n = 0; n < 20 && d_oe !== 1'b0; n++) @(negedge clk);
    hang |= (n == 20);
    ack_rd = 1'b0;
    @(negedge clk);
  endtask : dma_read
  // Address goes out bit 0 first with enable low; the line idles high through its pull-up
  task automatic ser_read(input logic [7:0] a, output logic [23:0] q);
    @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      ser_di = a[i];
      repeat (6) @(negedge clk);
      ser_cl = 1'b1;
      repeat (6) @(negedge clk);
      ser_cl = 1'b0;
    end
    repeat (6) @(negedge clk);
    ser_ce = 1'b1;
    for (int i = 0; i < 24; i++) begin
      repeat (8) @(negedge clk);
      q[i] = ~ser_do_oe;
      ser_cl = 1'b1;
      repeat (6) @(negedge clk);
      ser_cl = 1'b0;
    end
    ser_ce = 1'b0;
    repeat (8) @(negedge clk);
  endtask : ser_read
  // Strobe held until the device answers; data taken at that same edge
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    int n;
    @(negedge clk);
    addr = a;
    {cs_n, rd_n} = 2'b00;
    for (n = 0; n < 20 && d_oe !== 1'b1; n++) @(negedge clk);
    hang |= (n == 20);
    q = d_out;
    {cs_n, rd_n} = 2'b11;
    for (n = 0; n < 20 && d_oe !== 1'b0; n++) @(negedge clk);
    hang |= (n == 20);
    @(negedge clk);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [7:0] b);
    @(negedge clk);
    addr = a;
    d_in = {8'h00, b};
    {cs_n, wr_n} = 2'b00;
    repeat (6) @(negedge clk);
    {cs_n, wr_n} = 2'b11;
    d_in = ~d_in; // Released bus does not keep the last byte
    repeat (6) @(negedge clk);
  endtask : wr
  task automatic clear_group();
    @(negedge clk);
    clr = 1'b1;
    repeat (2) @(negedge clk);
    clr = 1'b0;
  endtask : clear_group
endmodule : host_port_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the packet status readout block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import packet_status_pkg::*;
  logic          clk_sys, rst_n, pkt_valid, vertical_correction_halt, bus_16, dma_en, dma_request_hi, good, bad;
  packet_info_s  info;
  frame_method_e method;
  logic [191:0]  raw;
  logic [31:0]   seed, r;
  logic [15:0]   rem, q;
  logic [7:0]    exp_st, b, last_ix;
  logic          cs_n, rd_n, wr_n, clr, d_oe, dma_req, int_n, gc_ok;
  logic          rt, dma_acknowledge, ack_rd, ser_ce, ser_cl, ser_di, ser_do_oe;
  logic [23:0]   sq;
  logic [3:0]    addr;
  logic [15:0]   d_in, d_out;
  int            failures, checks;

  host_port_model host (.clk(clk_sys), .d_out(d_out), .d_oe(d_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .d_in(d_in), .clr(clr), .ser_do_oe(ser_do_oe), .dma_acknowledge(dma_acknowledge), .ack_rd(ack_rd),
    .ser_ce(ser_ce), .ser_cl(ser_cl), .ser_di(ser_di));
  packet_status_readout dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PKT_VALID(pkt_valid), .PKT_INFO(info),
    .FRAME_METHOD(method), .VERTICAL_CORRECTION_HALT(vertical_correction_halt), .GROUP_CHECK_CLEAR(clr), .BUS_16(bus_16), .DMA_EN(dma_en),
    .DMA_READ_ON_ACK(ack_rd), .DMA_REQUEST_ACTIVE_HIGH(dma_request_hi), .DMA_ACKNOWLEDGE_ACTIVE_HIGH(dma_request_hi), .CS_N(cs_n), .RD_N(rd_n),
    .WR_N(wr_n), .ADDR(addr), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .DMA_ACK(dma_acknowledge), .DMA_REQ(dma_req),
    .INT_N(int_n), .GROUP_CHECK_OK(gc_ok), .SER_CE(ser_ce), .SER_CL(ser_cl), .SER_DI(ser_di), .SER_DO_OUT(),
    .SER_DO_OE(ser_do_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Bitwise long division, first bit of each byte first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction : crc_step
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    conclude();
  end
  initial begin
    {rst_n, pkt_valid, vertical_correction_halt, bus_16, dma_en, dma_request_hi, good} = 7'h00;
    {failures, checks, seed, rem, last_ix} = {32'd0, 32'd0, 32'h29, 16'h0000, 8'h00};
    {info, method} = '0;
    repeat (16) @(posedge clk_sys);
    chk("reset outputs", {13'h0, int_n, gc_ok, d_oe}, 16'h0006);
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      bad = (i % 3 == 2);
      if (!good) host.clear_group();
      if (!good) rem = CRC_INIT;
      for (int k = 0; k < 6; k++) begin
        r = rnd();
        // Once the high check byte is in, the low one has moved up to the top of the remainder
        b = (k < 4) ? r[7:0] : rem[15:8] ^ {7'h00, bad & (k == 5)};
        host.wr(ADDR_CHECK_IN, b);
        rem = crc_step(rem, b);
      end
      good = (rem == 16'h0000);
      chk("group ok pin", {15'h0, gc_ok}, {15'h0, good});
      r = rnd();
      raw = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      @(negedge clk_sys);
      {vertical_correction_halt, bus_16, dma_en, dma_request_hi} = r[3:0];
      method = frame_method_e'(r[5:4]);
      info = raw[190:0];
      if (info.is_parity) info.vh_applied = 1'b0;
      info.block_index = info.is_parity ? r[13:6] % 8'd82 : r[13:6] % 8'd190;
      pkt_valid = 1'b1;
      @(negedge clk_sys);
      pkt_valid = 1'b0;
      @(negedge clk_sys);
      chk("int before update", {15'h0, int_n}, 16'h0001);
      repeat (2) @(negedge clk_sys);
      chk("int after update", {15'h0, int_n}, 16'h0000);
      if (dma_en) chk("dma request", {15'h0, dma_req}, {15'h0, dma_request_hi});
      rt = info.is_realtime & (method == METHOD_A_PRIME);
      exp_st = {info.vh_applied & ~rt, info.block_locked, info.frame_locked, info.uncorrectable,
        info.is_parity & ~rt, info.is_head, good, rt};
      host.rd(ADDR_STATUS, q);
      if (exp_st[7]) q[2] = 1'b0;
      if (exp_st[7]) exp_st[2] = 1'b0;
      chk("status", {8'h00, q[7:0]}, {8'h00, exp_st});
      // Index register also
      host.rd(ADDR_INDEX, q);
      last_ix = info.block_index;
      if (!vertical_correction_halt) chk("index", {8'h00, q[7:0]}, {8'h00, last_ix});
      host.ser_read(SER_ADDR_DATA, sq);
      if (exp_st[7]) sq[2] = 1'b0;
      for (int j = 0; j < 8; j++) b[j] = info.data[175 - j];
      chk("serial status", {8'h00, sq[7:0]}, {8'h00, exp_st});
      if (!vertical_correction_halt) chk("serial index", {8'h00, sq[15:8]}, {8'h00, last_ix});
      chk("serial data", {8'h00, sq[23:16]}, {8'h00, b});
      chk("serial release", {15'h0, ser_do_oe}, 16'h0000);
      for (int k = 0; k < 23; k += (bus_16 ? 2 : 1)) begin
        if (k == 0 && dma_en) host.dma_read(dma_request_hi, q);
        else host.rd(ADDR_DATA, q);
        if (k >= 22) chk("data tail", q, 16'h0000);
        else if (bus_16) chk("data word", q, info.data[175-8*k -: 16]);
        else chk("data byte", q, {8'h00, info.data[175-8*k -: 8]});
      end
      chk("dma idle", {15'h0, dma_req}, {15'h0, ~dma_request_hi});
      if (i != 4) continue;
      @(negedge clk_sys);
      {info.vh_applied, info.is_parity, info.block_index, pkt_valid} = {2'b11, ~last_ix, 1'b1};
      @(negedge clk_sys);
      pkt_valid = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk("parity after vertical", {15'h0, int_n}, 16'h0000);
      host.rd(ADDR_INDEX, q);
      if (!vertical_correction_halt) chk("index kept", {8'h00, q[7:0]}, {8'h00, last_ix});
    end
    chk("host waits", {15'h0, host.hang}, 16'h0000);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
